// >>> hdl/fo_fail_outputs.sv
// Fail output logic: failure latch, pin waveforms and APB registers.
// Notes on behaviour
// RL1: Watchdog, thermal stage two, supply short activate outputs.
// RL2: Watchdog activates on second failure, configs three/four.
// RL3: Overvoltage counts only with its enable set.
// RL4: Four undervoltage events activate the outputs.
// RL5: Fail-safe entry accompanies activation; watchdog per config.
// RL6: Activation by failure sets the fail active flag.
// RL7: Force bit drives outputs, independent of failures.
// RL8: Clearing force releases outputs when no failure.
// RL9: Release needs no condition and flag cleared.
// RL10: Controller clears watchdog flag before clearing fail flag.
// RL11: Sleep, other fail-safe, stop disable clear watchdog flag.
// RL12: Config two's first watchdog failure sets no flag.
// RL13: All three outputs activate together, own waveforms.
// RL14: Outputs are open drain, pulled low when active.
// RL15: Static output held low while active.
// RL16: Blink output toggles 1.25 Hz, half duty.
// RL17: PWM output 100 Hz, default 20 percent low.
// RL18: PWM duty selectable 20, 10, 5, 2.5 percent.
// RL19: Failure activation survives restart and normal mode entry.
// RL20: Pattern counters start at activation; reset releases outputs.
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
module fo_fail_outputs #(
  parameter int BLINK_HALF_CYC = fo_pkg::FO_BLINK_HALF_CYC,
  parameter int PWM_PERIOD_CYC = fo_pkg::FO_PWM_PERIOD_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Failure sources from device logic, same clock
  input wire logic [1:0] hw_config,
  input wire logic wd_trigger_fail,
  input wire logic wd_trigger_ok,
  input wire logic thermal_shutdown_stage_two,
  input wire logic main_supply_short,
  input wire logic main_supply_ov,
  input wire logic main_supply_uv_event,
  input wire logic normal_mode,
  input wire logic sleep_entry,
  input wire logic stop_wd_disable,
  output logic failsafe_entry,
  // Open-drain pins
  input wire logic static_fail_out_i,
  output logic static_fail_out_o,
  output logic static_fail_out_oe,
  input wire logic blink_fail_out_i,
  output logic blink_fail_out_o,
  output logic blink_fail_out_oe,
  input wire logic pwm_fail_out_i,
  output logic pwm_fail_out_o,
  output logic pwm_fail_out_oe
);
  import fo_pkg::*;

  typedef struct packed {
    logic force_on;
    logic ov_en;
    logic [1:0] duty;
    logic flag;
    logic wd_flag;
    logic [1:0] wd_cnt;
    logic [2:0] uv_cnt;
    logic latch;
    logic cond_prev;
    logic fs_pulse;
    logic [FO_BLINK_W-1:0] blink_cnt;
    logic [FO_PWM_W-1:0] pwm_cnt;
    logic [2:0] oe;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [31:0] rdata;
  } fo_state_t;

  fo_state_t s_reg;
  fo_state_t s_next;

  logic setup_ph;
  logic access_ph;
  logic wr_ctrl;
  logic wr_stat;
  logic addr_ok;
  logic cond_other;
  logic cond_any;
  logic wd_hit;
  logic uv_hit;
  logic fail_set;
  logic flag_set;
  logic clr_req;
  logic release_ok;
  logic active_next;
  logic [FO_PWM_W-1:0] duty_cyc;

  assign addr_ok = (paddr == FO_CTRL_ADDR) || (paddr == FO_STATUS_ADDR);
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access_ph && !addr_ok;
  assign prdata = s_reg.rdata;
  assign wr_ctrl = access_ph && pwrite && pstrb[0] &&
                   (paddr == FO_CTRL_ADDR);
  assign wr_stat = access_ph && pwrite && pstrb[0] &&
                   (paddr == FO_STATUS_ADDR);
  assign failsafe_entry = s_reg.fs_pulse;
  // Open drain: the driven level is always low, only the enable moves
  assign static_fail_out_o = 1'b0; // RL14
  assign blink_fail_out_o = 1'b0; // RL14
  assign pwm_fail_out_o = 1'b0; // RL14
  assign static_fail_out_oe = s_reg.oe[0];
  assign blink_fail_out_oe = s_reg.oe[1];
  assign pwm_fail_out_oe = s_reg.oe[2];

  always_comb begin
    unique case (s_reg.duty) // RL18
      2'h0: duty_cyc = FO_PWM_W'(PWM_PERIOD_CYC / 5);
      2'h1: duty_cyc = FO_PWM_W'(PWM_PERIOD_CYC / 10);
      2'h2: duty_cyc = FO_PWM_W'(PWM_PERIOD_CYC / 20);
      2'h3: duty_cyc = FO_PWM_W'(PWM_PERIOD_CYC / 40);
    endcase
  end

  // Conditions other than the watchdog: levels plus the fourth undervoltage event
  assign cond_other = thermal_shutdown_stage_two || main_supply_short || // RL1
                      (main_supply_ov && s_reg.ov_en) || uv_hit; // RL3
  assign uv_hit = main_supply_uv_event &&
                  (s_reg.uv_cnt == FO_UV_LIMIT - 3'h1); // RL4
  // First failure counts for configs one/two, second for three/four
  assign wd_hit = wd_trigger_fail &&
                  (!hw_config[1] || s_reg.wd_cnt != 2'h0); // RL2
  assign fail_set = cond_other || wd_hit;
  // Config two's first watchdog failure drives pins but not the flag
  assign flag_set = cond_other ||
                    (wd_hit && !(hw_config == 2'h1 &&
                                 s_reg.wd_cnt == 2'h0)); // RL12
  assign cond_any = thermal_shutdown_stage_two || main_supply_short ||
                    (main_supply_ov && s_reg.ov_en) || s_reg.wd_flag;
  assign clr_req = wr_stat && pwdata[FO_FLAG_BIT];
  // Release only in normal mode once every cause has gone
  assign release_ok = clr_req && normal_mode && !cond_any; // RL9 RL10

  always_comb begin
    s_next = s_reg;
    s_next.fs_pulse = 1'b0;
    s_next.cond_prev = cond_other;
    s_next.sync1 = {pwm_fail_out_i, blink_fail_out_i, static_fail_out_i};
    s_next.sync2 = s_reg.sync1;
    if (wr_ctrl) begin
      s_next.force_on = pwdata[FO_FORCE_BIT]; // RL7 RL8
      s_next.ov_en = pwdata[FO_OV_EN_BIT];
      s_next.duty = pwdata[FO_DUTY_LSB+:2]; // RL18
    end
    if (main_supply_uv_event && s_reg.uv_cnt < FO_UV_LIMIT) begin
      s_next.uv_cnt = s_reg.uv_cnt + 3'h1; // RL4
    end
    if (wd_trigger_fail && s_reg.wd_cnt != 2'h3) begin
      s_next.wd_cnt = s_reg.wd_cnt + 2'h1;
    end
    // Fail-safe entry: non-watchdog causes always, watchdog in config 4
    if ((cond_other && !s_reg.cond_prev) ||
        (wd_hit && hw_config == 2'h3)) begin
      s_next.fs_pulse = 1'b1; // RL5
    end
    if (release_ok) begin
      s_next.flag = 1'b0;
      s_next.latch = 1'b0;
      s_next.uv_cnt = 3'h0;
      s_next.wd_cnt = 2'h0;
    end
    // Restart and normal mode entry do not touch the latch
    if (fail_set) begin
      s_next.latch = 1'b1; // RL1 RL19
    end
    if (flag_set) begin
      s_next.flag = 1'b1; // RL6
    end
    if (wd_trigger_ok || sleep_entry || stop_wd_disable ||
        (cond_other && !s_reg.cond_prev)) begin
      s_next.wd_flag = 1'b0; // RL11
    end
    if (wd_trigger_fail) begin
      s_next.wd_flag = 1'b1;
    end
    active_next = s_next.latch || s_next.force_on;
    // Counters idle at zero, so each waveform starts pulled low
    if (!(s_reg.latch || s_reg.force_on) ||
        s_reg.blink_cnt == FO_BLINK_W'(2 * BLINK_HALF_CYC - 1)) begin
      s_next.blink_cnt = '0; // RL20
    end else begin
      s_next.blink_cnt = s_reg.blink_cnt + 1'b1;
    end
    if (!(s_reg.latch || s_reg.force_on) ||
        s_reg.pwm_cnt == FO_PWM_W'(PWM_PERIOD_CYC - 1)) begin
      s_next.pwm_cnt = '0; // RL20
    end else begin
      s_next.pwm_cnt = s_reg.pwm_cnt + 1'b1;
    end
    if (!(s_reg.latch || s_reg.force_on)) begin
      s_next.blink_cnt = '0;
      s_next.pwm_cnt = '0;
    end
    s_next.oe[0] = active_next; // RL13 RL15
    s_next.oe[1] = active_next &&
                   s_next.blink_cnt < FO_BLINK_W'(BLINK_HALF_CYC); // RL16
    s_next.oe[2] = active_next && s_next.pwm_cnt < duty_cyc; // RL17
    if (setup_ph) begin
      s_next.rdata = 32'h0000_0000;
      if (paddr == FO_CTRL_ADDR) begin
        s_next.rdata[FO_FORCE_BIT] = s_reg.force_on;
        s_next.rdata[FO_OV_EN_BIT] = s_reg.ov_en;
        s_next.rdata[FO_DUTY_LSB+:2] = s_reg.duty;
      end else if (paddr == FO_STATUS_ADDR) begin
        s_next.rdata[FO_FLAG_BIT] = s_reg.flag;
        s_next.rdata[FO_WDF_BIT] = s_reg.wd_flag;
        s_next.rdata[FO_PIN_LSB+:3] = s_reg.sync2;
        s_next.rdata[FO_ACT_BIT] = s_reg.latch || s_reg.force_on;
        s_next.rdata[FO_UV_LSB+:3] = s_reg.uv_cnt;
        s_next.rdata[FO_WD_LSB+:2] = s_reg.wd_cnt;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0; // RL20
      s_reg.duty <= FO_DUTY_RESET; // RL18
      s_reg.sync1 <= 3'h7;
      s_reg.sync2 <= 3'h7;
    end else begin
      s_reg <= s_next;
    end
  end

  sequence fo_fault_seen;
    thermal_shutdown_stage_two || main_supply_short;
  endsequence

  sequence fo_pins_pulled;
    static_fail_out_oe && blink_fail_out_oe && pwm_fail_out_oe;
  endsequence

  a_fault_sets_flag: assert property ( // RL1
    @(posedge mclk) disable iff (rst)
    fo_fault_seen |=> s_reg.flag && s_reg.latch && static_fail_out_oe)
    else $error("fault did not activate outputs");

  a_pins_together: assert property ( // RL13
    @(posedge mclk) disable iff (rst)
    $rose(static_fail_out_oe) |-> fo_pins_pulled)
    else $error("outputs did not start together");

  a_force_drives: assert property ( // RL7
    @(posedge mclk) disable iff (rst)
    s_reg.force_on |-> static_fail_out_oe)
    else $error("force bit not driving static output");

  a_force_release: assert property ( // RL8
    @(posedge mclk) disable iff (rst)
    !s_reg.latch && !s_reg.force_on |-> !static_fail_out_oe &&
    !blink_fail_out_oe && !pwm_fail_out_oe)
    else $error("outputs active without cause");

  a_release_cause: assert property ( // RL9
    @(posedge mclk) disable iff (rst)
    $fell(s_reg.latch) |-> $past(clr_req) && $past(normal_mode))
    else $error("latch released without flag clear");

  a_wd_second: assert property ( // RL2
    @(posedge mclk) disable iff (rst)
    wd_trigger_fail && hw_config[1] && s_reg.wd_cnt == 2'h0 &&
    !s_reg.latch && !cond_other |=> !s_reg.latch)
    else $error("first watchdog failure activated in config 3/4");

  a_wd_first: assert property ( // RL2
    @(posedge mclk) disable iff (rst)
    wd_trigger_fail && !hw_config[1] |=> s_reg.latch ##1 s_reg.oe[0])
    else $error("watchdog failure did not activate in config 1/2");

  a_cfg2_noflag: assert property ( // RL12
    @(posedge mclk) disable iff (rst)
    wd_trigger_fail && hw_config == 2'h1 && s_reg.wd_cnt == 2'h0 &&
    !s_reg.flag && !cond_other |=> !s_reg.flag)
    else $error("flag set on first config 2 watchdog failure");

  a_uv_fourth: assert property ( // RL4
    @(posedge mclk) disable iff (rst)
    main_supply_uv_event && s_reg.uv_cnt == 3'h3 |=>
    s_reg.latch && s_reg.flag && failsafe_entry)
    else $error("fourth undervoltage event missed");

  a_sleep_clears: assert property ( // RL11
    @(posedge mclk) disable iff (rst)
    sleep_entry && !wd_trigger_fail |=> !s_reg.wd_flag)
    else $error("sleep entry left watchdog flag set");

  // Looks back, not ahead, so a legal release does not trip it
  a_static_steady: assert property ( // RL15
    @(posedge mclk) disable iff (rst)
    s_reg.latch && $past(s_reg.latch) && $past(s_reg.latch, 2) |->
    static_fail_out_oe && $past(static_fail_out_oe) &&
    $past(static_fail_out_oe, 2))
    else $error("static output modulated");

  a_blink_wrap: assert property ( // RL16
    @(posedge mclk) disable iff (rst)
    (s_reg.latch || s_reg.force_on) &&
    s_reg.blink_cnt == FO_BLINK_W'(2 * BLINK_HALF_CYC - 1) |=>
    s_reg.blink_cnt == '0)
    else $error("blink counter did not wrap");

  a_blink_half: assert property ( // RL16
    @(posedge mclk) disable iff (rst)
    s_reg.blink_cnt == FO_BLINK_W'(BLINK_HALF_CYC) |-> !blink_fail_out_oe)
    else $error("blink output pulled in its high half");

  a_pwm_wrap: assert property ( // RL17
    @(posedge mclk) disable iff (rst)
    (s_reg.latch || s_reg.force_on) &&
    s_reg.pwm_cnt == FO_PWM_W'(PWM_PERIOD_CYC - 1) |=> s_reg.pwm_cnt == '0)
    else $error("pwm counter did not wrap");

  a_pwm_ceiling: assert property ( // RL18
    @(posedge mclk) disable iff (rst)
    s_reg.pwm_cnt >= FO_PWM_W'(PWM_PERIOD_CYC / 5) |-> !pwm_fail_out_oe)
    else $error("pwm output pulled beyond a fifth of its period");

  a_flag_cause: assert property ( // RL6
    @(posedge mclk) disable iff (rst)
    $rose(s_reg.flag) |-> $past(flag_set))
    else $error("fail active flag set without a failure");

  a_stop_clears: assert property ( // RL11
    @(posedge mclk) disable iff (rst)
    stop_wd_disable && !wd_trigger_fail |=> !s_reg.wd_flag)
    else $error("stop mode disable left watchdog flag set");

  a_failsafe_latch: assert property ( // RL5
    @(posedge mclk) disable iff (rst)
    failsafe_entry |-> s_reg.latch)
    else $error("fail-safe entry without output activation");
endmodule : fo_fail_outputs

// >>> hdl/fo_pkg.sv
// Constants shared by the fail output block: register map and timing.
package fo_pkg;
  localparam logic [11:0] FO_CTRL_ADDR = 12'h000;
  localparam logic [11:0] FO_STATUS_ADDR = 12'h004;
  // Control register fields
  localparam int FO_FORCE_BIT = 0;
  localparam int FO_OV_EN_BIT = 1;
  localparam int FO_DUTY_LSB = 2;
  localparam logic [1:0] FO_DUTY_RESET = 2'h0;
  // Status register fields; bit 0 is write-one-to-clear
  localparam int FO_FLAG_BIT = 0;
  localparam int FO_WDF_BIT = 1;
  localparam int FO_PIN_LSB = 2;
  localparam int FO_ACT_BIT = 5;
  localparam int FO_UV_LSB = 6;
  localparam int FO_WD_LSB = 9;
  // Fail-output triggers after this many undervoltage events
  localparam logic [2:0] FO_UV_LIMIT = 3'h4;
  // Timing, in the units given by the names
  localparam int FO_CLK_KHZ = 25000;
  localparam int FO_BLINK_PERIOD_MS = 800;
  localparam int FO_PWM_PERIOD_MS = 10;
  localparam int FO_BLINK_HALF_CYC = FO_BLINK_PERIOD_MS * FO_CLK_KHZ / 2;
  localparam int FO_PWM_PERIOD_CYC = FO_PWM_PERIOD_MS * FO_CLK_KHZ;
  localparam int FO_BLINK_W = $clog2(FO_BLINK_HALF_CYC * 2);
  localparam int FO_PWM_W = $clog2(FO_PWM_PERIOD_CYC);
endpackage : fo_pkg

// >>> test/fo_fail_outputs_tb.sv
// Self-checking bench for the fail output block.
`timescale 1ns/1ps
module fo_fail_outputs_tb;
  import fo_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] hw_config = 2'h0;
  logic [3:0] pz = 4'h0;
  logic [2:0] lv = 3'h0;
  logic normal_mode = 1'b0;
  logic stop_wd_disable = 1'b0;
  logic failsafe_entry;
  logic [2:0] o;
  logic [2:0] oe;
  logic [2:0] lvl;
  logic [31:0] rd;
  logic er;
  int mismatches = 0;
  int comparisons = 0;
  int ns;
  int nb;
  int np;

  fo_fail_outputs #(.BLINK_HALF_CYC(8), .PWM_PERIOD_CYC(40)) dut (
    .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .hw_config,
    .wd_trigger_fail(pz[0]), .wd_trigger_ok(pz[1]),
    .main_supply_uv_event(pz[2]), .sleep_entry(pz[3]),
    .thermal_shutdown_stage_two(lv[0]), .main_supply_short(lv[1]),
    .main_supply_ov(lv[2]), .normal_mode, .stop_wd_disable,
    .failsafe_entry,
    .static_fail_out_i(lvl[0]), .static_fail_out_o(o[0]),
    .static_fail_out_oe(oe[0]),
    .blink_fail_out_i(lvl[1]), .blink_fail_out_o(o[1]),
    .blink_fail_out_oe(oe[1]),
    .pwm_fail_out_i(lvl[2]), .pwm_fail_out_o(o[2]),
    .pwm_fail_out_oe(oe[2])
  );

  fo_lamp_model lamps (.drv_o(o), .drv_oe(oe), .pin_lvl(lvl));

  initial begin
    forever #20 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // Hold the request until pready is seen; the watchdog bounds the wait
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rst_dut(input logic [1:0] cfg);
    @(posedge mclk);
    rst <= 1'b1;
    hw_config <= cfg;
    pz <= 4'h0;
    lv <= 3'h0;
    normal_mode <= 1'b0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
  endtask : rst_dut

  // One-cycle event; returns just after the edge that answers it
  task automatic pulse(input int k);
    @(posedge mclk);
    pz[k] <= 1'b1;
    @(posedge mclk);
    pz[k] <= 1'b0;
    #1;
  endtask : pulse

  // Two PWM periods and five blink periods, so phase does not matter
  task automatic measure;
    ns = 0;
    nb = 0;
    np = 0;
    repeat (80) begin
      @(posedge mclk);
      #1;
      ns += (lvl[0] === 1'b0);
      nb += (lvl[1] === 1'b0);
      np += (lvl[2] === 1'b0);
    end
  endtask : measure

  task automatic release_chk(input logic [2:0] exp);
    apb(1'b1, FO_STATUS_ADDR, 32'h00000001);
    @(posedge mclk);
    #1;
    chk(oe, exp);
  endtask : release_chk

  task automatic t_reset;
    apb(1'b0, FO_CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, FO_STATUS_ADDR, 32'h0);
    chk(rd, 32'h1C);
    chk(oe, 3'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(er, 1'b1);
  endtask : t_reset

  task automatic t_thermal;
    @(posedge mclk);
    lv[0] <= 1'b1;
    @(posedge mclk);
    lv[0] <= 1'b0;
    #1;
    chk(oe, 3'h7);
    chk(failsafe_entry, 1'b1);
    measure();
    chk(ns, 80);
    chk(nb, 40);
    chk(np, 16);
    apb(1'b0, FO_STATUS_ADDR, 32'h0);
    chk(rd[0], 1'b1);
    chk(rd[FO_ACT_BIT], 1'b1);
    chk(rd[FO_PIN_LSB], 1'b0);
    release_chk(3'h7);
    @(posedge mclk);
    normal_mode <= 1'b1;
    release_chk(3'h0);
  endtask : t_thermal

  task automatic t_duty;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, FO_CTRL_ADDR, (k << FO_DUTY_LSB) | 1);
      measure();
      chk(np, 16 >> k);
      chk(ns, 80);
    end
    apb(1'b0, FO_STATUS_ADDR, 32'h0);
    chk(rd[0], 1'b0);
    apb(1'b1, FO_CTRL_ADDR, 32'h0);
    @(posedge mclk);
    #1;
    chk(oe, 3'h0);
  endtask : t_duty

  // Watchdog release: flag clear is refused until a good trigger
  task automatic t_wd(input logic [1:0] cfg);
    rst_dut(cfg);
    normal_mode <= 1'b1;
    pulse(0);
    if (cfg >= 2) begin
      chk(oe, 3'h0);
      pulse(0);
    end
    chk(oe, 3'h7);
    chk(failsafe_entry, cfg == 2'h3);
    apb(1'b0, FO_STATUS_ADDR, 32'h0);
    chk(rd[1:0], 2'h3);
    release_chk(3'h7);
    pulse(1);
    release_chk(3'h0);
  endtask : t_wd

  task automatic t_misc;
    rst_dut(2'h1);
    pulse(0);
    chk(oe, 3'h7);
    apb(1'b0, FO_STATUS_ADDR, 32'h0);
    chk(rd[0], 1'b0);
    rst_dut(2'h0);
    repeat (3) pulse(2);
    chk(oe, 3'h0);
    pulse(2);
    chk(oe, 3'h7);
    rst_dut(2'h0);
    lv[2] <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk(oe, 3'h0);
    apb(1'b1, FO_CTRL_ADDR, 32'h2);
    repeat (2) @(posedge mclk);
    #1;
    chk(oe, 3'h7);
    rst_dut(2'h0);
    pulse(0);
    apb(1'b0, FO_STATUS_ADDR, 32'h0);
    chk(rd[1], 1'b1);
    pulse(3);
    apb(1'b0, FO_STATUS_ADDR, 32'h0);
    chk(rd[1], 1'b0);
    pulse(0);
    @(posedge mclk);
    stop_wd_disable <= 1'b1;
    @(posedge mclk);
    stop_wd_disable <= 1'b0;
    apb(1'b0, FO_STATUS_ADDR, 32'h0);
    chk(rd[1], 1'b0);
    pulse(0);
    @(posedge mclk);
    lv[1] <= 1'b1;
    @(posedge mclk);
    lv[1] <= 1'b0;
    apb(1'b0, FO_STATUS_ADDR, 32'h0);
    chk(rd[1:0], 2'h1);
  endtask : t_misc

  initial begin
    #(5000 * 40);
    mismatches++;
    print_verdict();
  end

  initial begin
    rst_dut(2'h0);
    t_reset();
    t_thermal();
    t_duty();
    t_wd(2'h0);
    t_wd(2'h2);
    t_wd(2'h3);
    t_misc();
    print_verdict();
  end
endmodule : fo_fail_outputs_tb

// >>> test/fo_lamp_model.sv
// Lamp and pull-up model on the three open-drain fail pins.
`timescale 1ns/1ps
module fo_lamp_model (
  input wire logic [2:0] drv_o,
  input wire logic [2:0] drv_oe,
  output logic [2:0] pin_lvl
);
  // Pull-up wins whenever the driver lets go, so a release reads high
  assign pin_lvl = ~drv_oe | drv_o;
endmodule : fo_lamp_model
